// [include/dmove_pkg.sv]
package dmove_pkg;
	// Bus width variants
	localparam logic BUS_WIDE = 1'b0;
	localparam logic BUS_NARROW = 1'b1;
	// Prefetch queue depths in bytes
	localparam int QUEUE_DEPTH_WIDE = 6;
	localparam int QUEUE_DEPTH_NARROW = 4;
	localparam int QUEUE_CAP = 6;
	localparam int QCNT_W = 3;
	// Opcodes
	localparam logic [7:0] OPC_SEG_LOAD = 8'h8e;
	localparam logic [7:0] OPC_SEG_STORE = 8'h8c;
	localparam logic [7:0] OPC_TABLE_LOOKUP = 8'hd7;
	localparam logic [7:0] OPC_LOAD_EFF_ADDR = 8'h8d;
	localparam logic [7:0] OPC_FAR_DATASEG = 8'hc5;
	localparam logic [7:0] OPC_FAR_EXTRASEG = 8'hc4;
	localparam logic [7:0] OPC_FLAGS_TO_HIGH_ACC = 8'h9f;
	localparam logic [7:0] OPC_HIGH_ACC_TO_FLAGS = 8'h9e;
	localparam logic [6:0] OPC_MOVE_IMM_RM = 7'h63;
	localparam logic [1:0] MOD_REGISTER = 2'b11;
	// Addressing byte field positions and the opcode width bit
	localparam int MOD_HI = 7;
	localparam int MOD_LO = 6;
	localparam int REG_HI_BIT = 5;
	localparam int WIDTH_BIT = 0;
	// Minimum clock counts
	localparam logic [5:0] CYC_SEG_REG = 6'h02;
	localparam logic [5:0] CYC_SEG_LOAD_MEM_W = 6'h09;
	localparam logic [5:0] CYC_SEG_LOAD_MEM_N = 6'h0d;
	localparam logic [5:0] CYC_SEG_STORE_MEM_W = 6'h0b;
	localparam logic [5:0] CYC_SEG_STORE_MEM_N = 6'h0f;
	localparam logic [5:0] CYC_LOOKUP_W = 6'h0b;
	localparam logic [5:0] CYC_LOOKUP_N = 6'h0f;
	localparam logic [5:0] CYC_LOAD_EFF_ADDR = 6'h06;
	localparam logic [5:0] CYC_FAR_W = 6'h12;
	localparam logic [5:0] CYC_FAR_N = 6'h1a;
	localparam logic [5:0] CYC_FLAGS_TO_HIGH_ACC = 6'h02;
	localparam logic [5:0] CYC_HIGH_ACC_TO_FLAGS = 6'h03;
	localparam logic [5:0] CYC_MOVE_IMM_REG = 6'h0c;
	localparam logic [5:0] CYC_MOVE_IMM_MEM = 6'h0d;
	localparam logic [5:0] CYC_ONE = 6'h01;
	// Extra clocks of the bus handshake
	localparam logic [5:0] CYC_HANDSHAKE_MAX = 6'h02;
	// Decoded operation codes
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_SEG_LOAD = 4'h1,
		OP_SEG_STORE = 4'h2,
		OP_TABLE_LOOKUP = 4'h3,
		OP_LOAD_EFF_ADDR = 4'h4,
		OP_FAR_DATASEG = 4'h5,
		OP_FAR_EXTRASEG = 4'h6,
		OP_FLAGS_TO_HIGH_ACC = 4'h7,
		OP_HIGH_ACC_TO_FLAGS = 4'h8,
		OP_MOVE_IMM = 4'h9,
		OP_ILLEGAL = 4'hf
	} op_t;
	// Execution states, Gray along the usual path
	typedef enum logic [1:0] {
		ST_OPCODE = 2'b00,
		ST_MODRM = 2'b01,
		ST_IMM = 2'b11,
		ST_EXEC = 2'b10
	} state_t;
endpackage

// [rtl/data_move_timing.sv]
`timescale 1ns/1ps
module data_move_timing
	import dmove_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic bus_narrow,
	input wire logic [7:0] fill_data,
	input wire logic fill_valid,
	output logic fill_ready,
	input wire logic transfer_flush,
	input wire logic wait_state,
	input wire logic bus_hold,
	input wire logic mem_handshake,
	input wire logic odd_word_addr,
	output logic busy,
	output logic done,
	output dmove_pkg::op_t op_out,
	output logic word_op,
	output logic mem_operand,
	output logic [7:0] modrm_out,
	output logic [7:0] imm_low,
	output logic [7:0] imm_high,
	output logic illegal
);
	typedef struct packed {
		state_t st;
		op_t op;
		logic word;
		logic mem;
		logic [7:0] modrm;
		logic [7:0] imm_lo;
		logic [7:0] imm_hi;
		logic imm_second;
		logic [5:0] cnt;
		logic [5:0] extra;
		logic done;
		logic illegal;
		logic ready;
		logic busy;
	} s_t;
	s_t s_reg, s_next;
	logic [7:0] head_data;
	logic head_valid;
	logic head_take;
	logic qready;
	logic stall;
	logic [7:0] opc;
	logic is_mem;

	prefetch_queue u_queue (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.bus_narrow(bus_narrow),
		.flush(transfer_flush),
		.fill_data(fill_data),
		.fill_valid(fill_valid),
		.fill_ready(qready),
		.head_data(head_data),
		.head_valid(head_valid),
		.head_take(head_take)
	);

	function automatic logic [5:0] base_count(input op_t op, input logic m,
		input logic n);
		case (op)
			OP_SEG_LOAD: base_count = !m ? CYC_SEG_REG
				: (n ? CYC_SEG_LOAD_MEM_N : CYC_SEG_LOAD_MEM_W);
			OP_SEG_STORE: base_count = !m ? CYC_SEG_REG
				: (n ? CYC_SEG_STORE_MEM_N : CYC_SEG_STORE_MEM_W);
			OP_TABLE_LOOKUP: base_count = n ? CYC_LOOKUP_N
				: CYC_LOOKUP_W;
			OP_LOAD_EFF_ADDR: base_count = CYC_LOAD_EFF_ADDR;
			OP_FAR_DATASEG, OP_FAR_EXTRASEG: base_count = n ? CYC_FAR_N
				: CYC_FAR_W;
			OP_FLAGS_TO_HIGH_ACC: base_count = CYC_FLAGS_TO_HIGH_ACC;
			OP_HIGH_ACC_TO_FLAGS: base_count = CYC_HIGH_ACC_TO_FLAGS;
			OP_MOVE_IMM: base_count = m ? CYC_MOVE_IMM_MEM
				: CYC_MOVE_IMM_REG;
			default: base_count = CYC_ONE;
		endcase
	endfunction

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.ready = qready;
		head_take = 1'b0;
		opc = head_data;
		is_mem = head_data[MOD_HI:MOD_LO] != MOD_REGISTER;
		stall = wait_state || bus_hold;
		if (transfer_flush) begin
			s_next.st = ST_OPCODE;
			s_next.cnt = '0;
		end else begin
			case (s_reg.st)
				ST_OPCODE: begin
					if (head_valid) begin
						head_take = 1'b1;
						s_next.illegal = 1'b0;
						s_next.word = 1'b0;
						s_next.mem = 1'b0;
						s_next.imm_second = 1'b0;
						s_next.imm_lo = '0;
						s_next.imm_hi = '0;
						s_next.modrm = '0;
						s_next.st = ST_MODRM;
						if (opc == OPC_SEG_LOAD) begin
							s_next.op = OP_SEG_LOAD;
						end else if (opc == OPC_SEG_STORE) begin
							s_next.op = OP_SEG_STORE;
						end else if (opc == OPC_LOAD_EFF_ADDR) begin
							s_next.op = OP_LOAD_EFF_ADDR;
						end else if (opc == OPC_FAR_DATASEG) begin
							s_next.op = OP_FAR_DATASEG;
						end else if (opc == OPC_FAR_EXTRASEG) begin
							s_next.op = OP_FAR_EXTRASEG;
						end else if (opc[7:1] == OPC_MOVE_IMM_RM) begin
							s_next.op = OP_MOVE_IMM;
							s_next.word = opc[WIDTH_BIT];
						end else begin
							s_next.st = ST_EXEC;
							s_next.extra = '0;
							if (opc == OPC_TABLE_LOOKUP) begin
								s_next.op = OP_TABLE_LOOKUP;
								s_next.mem = 1'b1;
							end else if (opc == OPC_FLAGS_TO_HIGH_ACC) begin
								s_next.op = OP_FLAGS_TO_HIGH_ACC;
							end else if (opc == OPC_HIGH_ACC_TO_FLAGS) begin
								s_next.op = OP_HIGH_ACC_TO_FLAGS;
							end else begin
								s_next.op = OP_ILLEGAL;
								s_next.illegal = 1'b1;
							end
							s_next.cnt = base_count(s_next.op, s_next.mem,
								bus_narrow);
						end
					end
				end
				ST_MODRM: begin
					if (head_valid) begin
						head_take = 1'b1;
						s_next.modrm = head_data;
						s_next.mem = is_mem;
						s_next.extra = '0;
						s_next.st = ST_EXEC;
						if ((s_reg.op == OP_SEG_LOAD
							&& head_data[REG_HI_BIT])
							|| ((s_reg.op == OP_FAR_DATASEG
							|| s_reg.op == OP_FAR_EXTRASEG) && !is_mem)) begin
							s_next.op = OP_ILLEGAL;
							s_next.illegal = 1'b1;
						end else if (s_reg.op == OP_MOVE_IMM) begin
							s_next.st = ST_IMM;
						end
						s_next.cnt = base_count(s_next.op, is_mem, bus_narrow);
					end
				end
				ST_IMM: begin
					if (head_valid) begin
						head_take = 1'b1;
						if (!s_reg.imm_second) begin
							s_next.imm_lo = head_data;
							s_next.imm_second = s_reg.word;
							if (!s_reg.word) begin
								s_next.st = ST_EXEC;
							end
						end else begin
							s_next.imm_hi = head_data;
							s_next.st = ST_EXEC;
						end
					end
				end
				ST_EXEC: begin
					if (s_reg.mem && mem_handshake
						&& s_reg.extra < CYC_HANDSHAKE_MAX) begin
						s_next.extra = s_reg.extra + 6'h01;
					end else if (s_reg.mem && s_reg.word && odd_word_addr
						&& !bus_narrow && s_reg.extra == '0) begin
						s_next.extra = 6'h01;
					end else if (stall) begin
						s_next.cnt = s_reg.cnt;
					end else if (s_reg.cnt > CYC_ONE) begin
						s_next.cnt = s_reg.cnt - 6'h01;
					end else begin
						s_next.cnt = '0;
						s_next.done = 1'b1;
						s_next.st = ST_OPCODE;
					end
				end
				default: s_next.st = ST_OPCODE;
			endcase
		end
		// Busy is registered so the output comes from a flop
		s_next.busy = (s_next.st != ST_OPCODE);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '{st: ST_OPCODE, op: OP_NONE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign fill_ready = s_reg.ready;
	assign busy = s_reg.busy;
	assign done = s_reg.done;
	assign op_out = s_reg.op;
	assign word_op = s_reg.word;
	assign mem_operand = s_reg.mem;
	assign modrm_out = s_reg.modrm;
	assign imm_low = s_reg.imm_lo;
	assign imm_high = s_reg.imm_hi;
	assign illegal = s_reg.illegal;
endmodule

// [rtl/prefetch_queue.sv]
`timescale 1ns/1ps
module prefetch_queue
	import dmove_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic bus_narrow,
	input wire logic flush,
	input wire logic [7:0] fill_data,
	input wire logic fill_valid,
	output logic fill_ready,
	output logic [7:0] head_data,
	output logic head_valid,
	input wire logic head_take
);
	typedef struct packed {
		logic [QUEUE_CAP-1:0][7:0] mem;
		logic [QCNT_W-1:0] rd;
		logic [QCNT_W-1:0] wr;
		logic [QCNT_W-1:0] cnt;
	} q_t;
	q_t q_reg, q_next;
	logic [QCNT_W-1:0] depth;
	logic push, pop;
	function automatic logic [QCNT_W-1:0] inc(input logic [QCNT_W-1:0] p);
		inc = (p == QCNT_W'(QUEUE_CAP - 1)) ? '0 : p + 1'b1;
	endfunction
	always_comb begin
		depth = bus_narrow ? QCNT_W'(QUEUE_DEPTH_NARROW)
			: QCNT_W'(QUEUE_DEPTH_WIDE);
		fill_ready = !flush && (q_reg.cnt < depth);
		head_valid = !flush && (q_reg.cnt != '0);
		head_data = q_reg.mem[q_reg.rd];
		push = fill_valid && fill_ready;
		pop = head_take && head_valid;
		q_next = q_reg;
		if (flush) begin
			q_next.rd = '0;
			q_next.wr = '0;
			q_next.cnt = '0;
		end else begin
			if (push) begin
				q_next.mem[q_reg.wr] = fill_data;
				q_next.wr = inc(q_reg.wr);
			end
			if (pop) begin
				q_next.rd = inc(q_reg.rd);
			end
			q_next.cnt = q_reg.cnt + QCNT_W'(push) - QCNT_W'(pop);
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end
endmodule

// [testbench/data_move_timing_chk.sv]
`timescale 1ns/1ps
module data_move_timing_chk
	import dmove_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic transfer_flush,
	input wire logic wait_state,
	input wire logic bus_hold,
	input wire logic busy,
	input wire logic done,
	input wire dmove_pkg::op_t op_out,
	input wire logic mem_operand,
	input wire logic [7:0] modrm_out,
	input wire logic illegal
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
	done_busy_a: assert property (done |-> $past(busy))
		else $error("done without busy");
	flags_high_count_a: assert property (
		$rose(busy) && op_out == OP_FLAGS_TO_HIGH_ACC
		##0 (!(wait_state || bus_hold || transfer_flush))[*3] |-> done)
		else $error("flags to high byte count wrong");
	high_flags_count_a: assert property (
		$rose(busy) && op_out == OP_HIGH_ACC_TO_FLAGS
		##0 (!(wait_state || bus_hold || transfer_flush))[*4] |-> done)
		else $error("high byte to flags count wrong");
	flush_abort_a: assert property (transfer_flush |=> !busy && !done)
		else $error("flush did not abort");
	stall_hold_a: assert property (
		(wait_state || bus_hold) && busy && !done |=> !done)
		else $error("stall did not freeze");
	illegal_op_a: assert property (illegal |-> op_out == OP_ILLEGAL)
		else $error("illegal flag without illegal op");
	far_mem_a: assert property (
		done && op_out inside {OP_FAR_DATASEG, OP_FAR_EXTRASEG}
		|-> modrm_out[7:6] != MOD_REGISTER)
		else $error("far pointer on register");
	seg_mem_a: assert property (
		done && op_out inside {OP_SEG_LOAD, OP_SEG_STORE}
		|-> mem_operand == (modrm_out[7:6] != MOD_REGISTER))
		else $error("memory flag wrong");
endmodule

// [testbench/fetch_feeder.sv]
`timescale 1ns/1ps
module fetch_feeder (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic fill_ready,
	output logic [7:0] fill_data,
	output logic fill_valid
);
	logic [7:0] q[$];
	task give(input logic [7:0] b);
		q.push_back(b);
	endtask
	task clear();
		q.delete();
	endtask
	// Keeps the queue topped up one byte a cycle while room is shown
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fill_valid <= 1'b0;
			fill_data <= 8'h00;
		end else if (fill_ready && q.size() > 0) begin
			fill_valid <= 1'b1;
			fill_data <= q.pop_front();
		end else begin
			fill_valid <= 1'b0;
			fill_data <= ~fill_data;
		end
	end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import dmove_pkg::*;
	logic clk_sys = 1'b0, arst_n = 1'b0, bus_narrow = 1'b0;
	logic transfer_flush = 1'b0, wait_state = 1'b0, bus_hold = 1'b0;
	logic mem_handshake = 1'b0, odd_word_addr = 1'b0;
	logic [7:0] fill_data, modrm_out, imm_low, imm_high;
	logic fill_valid, fill_ready, busy, done, word_op, mem_operand, illegal;
	op_t op_out;
	int miscompares = 0;
	int check_count = 0;
	int a, c;
	always #50 clk_sys = ~clk_sys;
	fetch_feeder fetch_feeder_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.fill_ready(fill_ready), .fill_data(fill_data), .fill_valid(fill_valid));
	data_move_timing data_move_timing_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.bus_narrow(bus_narrow), .fill_data(fill_data), .fill_valid(fill_valid),
		.fill_ready(fill_ready), .transfer_flush(transfer_flush),
		.wait_state(wait_state), .bus_hold(bus_hold),
		.mem_handshake(mem_handshake), .odd_word_addr(odd_word_addr),
		.busy(busy), .done(done), .op_out(op_out), .word_op(word_op),
		.mem_operand(mem_operand), .modrm_out(modrm_out), .imm_low(imm_low),
		.imm_high(imm_high), .illegal(illegal));
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task close_out();
		$display("miscompares %0d check_count %0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Queues bytes, stalls three cycles if asked, returns clocks to done
	task run(input logic [7:0] b[4], input int nb, input logic [1:0] st,
		output int lat);
		int n;
		n = 0;
		for (int i = 0; i < nb; i++) fetch_feeder_inst.give(b[i]);
		for (int i = 0; i < 300; i++) begin
			@(posedge clk_sys);
			{bus_hold, wait_state} <= (n >= 1 && n <= 3) ? st : 2'b00;
			#1;
			if (busy || done) n++;
			if (done) break;
		end
		if (!done) begin
			miscompares++;
			close_out();
		end
		lat = n - 1;
	endtask
	task s_counts();
		logic [7:0] oc[10] = '{8'h8e, 8'h8e, 8'h8c, 8'h8c, 8'h8d, 8'hc5, 8'hc4,
			8'hd7, 8'h9f, 8'h9e};
		logic [7:0] md[10] = '{8'hc0, 8'h07, 8'hc0, 8'h07, 8'h07, 8'h07, 8'h07,
			8'h00, 8'h00, 8'h00};
		int cw[10] = '{2, 9, 2, 11, 6, 18, 18, 11, 2, 3};
		int cn[10] = '{2, 13, 2, 15, 6, 26, 26, 15, 2, 3};
		op_t ex[10] = '{OP_SEG_LOAD, OP_SEG_LOAD, OP_SEG_STORE, OP_SEG_STORE,
			OP_LOAD_EFF_ADDR, OP_FAR_DATASEG, OP_FAR_EXTRASEG, OP_TABLE_LOOKUP,
			OP_FLAGS_TO_HIGH_ACC, OP_HIGH_ACC_TO_FLAGS};
		int k;
		int k2;
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys) bus_narrow <= v[0];
			run('{8'h8e, 8'hc0, 8'h00, 8'h00}, 2, 2'b00, a);
			k = a - 2;
			for (int i = 0; i < 10; i++) begin
				run('{oc[i], md[i], 8'h00, 8'h00}, i < 7 ? 2 : 1, 2'b00, a);
				chk("op", op_out, ex[i]);
				k2 = (v ? cn[i] : cw[i]) + (i < 7 ? k : 0);
				chk("clocks", a, k2);
			end
		end
	endtask
	task s_width();
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys) bus_narrow <= v[0];
			run('{8'hc7, 8'h07, 8'h34, 8'h12}, 4, 2'b00, a);
			chk("imm", {word_op, imm_high, imm_low}, 17'h11234);
			@(posedge clk_sys) odd_word_addr <= 1'b1;
			run('{8'hc7, 8'h07, 8'h34, 8'h12}, 4, 2'b00, c);
			odd_word_addr <= 1'b0;
			chk("odd word", c, a + (v ? 0 : 1));
		end
		run('{8'hc6, 8'hc0, 8'h55, 8'h9f}, 4, 2'b00, a);
		chk("byte imm", {word_op, imm_low}, 9'h055);
		run('{8'h00, 8'h00, 8'h00, 8'h00}, 0, 2'b00, a);
		chk("next op", {op_out, a[3:0]}, {OP_FLAGS_TO_HIGH_ACC, 4'h2});
	endtask
	task s_stall();
		run('{8'h9f, 8'h00, 8'h00, 8'h00}, 1, 2'b01, a);
		chk("wait stall", a, 5);
		run('{8'h9e, 8'h00, 8'h00, 8'h00}, 1, 2'b10, a);
		chk("hold stall", a, 6);
		run('{8'h8e, 8'h07, 8'h00, 8'h00}, 2, 2'b00, a);
		@(posedge clk_sys) mem_handshake <= 1'b1;
		run('{8'h8e, 8'h07, 8'h00, 8'h00}, 2, 2'b00, c);
		mem_handshake <= 1'b0;
		chk("handshake", c, a + CYC_HANDSHAKE_MAX);
		run('{8'h0f, 8'h00, 8'h00, 8'h00}, 1, 2'b00, a);
		chk("unlisted", {illegal, op_out, a[3:0]}, {1'b1, OP_ILLEGAL, 4'h1});
		run('{8'h8e, 8'hf8, 8'h00, 8'h00}, 2, 2'b00, a);
		chk("seg reg field", illegal, 1);
	endtask
	task s_depth(input logic v, input int extra, input logic low);
		logic seen;
		seen = 1'b0;
		@(posedge clk_sys) bus_narrow <= v;
		fetch_feeder_inst.give(8'hd7);
		for (int i = 0; i < extra; i++) fetch_feeder_inst.give(8'h9f);
		repeat (12) begin
			@(posedge clk_sys);
			#1;
			if (!fill_ready) seen = 1'b1;
		end
		chk("queue full", seen, low);
		fetch_feeder_inst.clear();
		@(posedge clk_sys) transfer_flush <= 1'b1;
		@(posedge clk_sys) transfer_flush <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("flushed", busy, 0);
		run('{8'h9f, 8'h00, 8'h00, 8'h00}, 1, 2'b00, a);
		chk("after flush", {op_out, a[3:0]}, {OP_FLAGS_TO_HIGH_ACC, 4'h2});
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		chk("reset", {fill_ready, busy, op_out}, {2'b00, OP_NONE});
		arst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("ready", fill_ready, 1);
		s_counts();
		s_width();
		@(posedge clk_sys) bus_narrow <= 1'b0;
		s_stall();
		s_depth(1'b1, 4, 1'b1);
		s_depth(1'b0, 4, 1'b0);
		s_depth(1'b0, 6, 1'b1);
		close_out();
	end
endmodule
bind data_move_timing data_move_timing_chk data_move_timing_chk_inst (
	.clk_sys(clk_sys), .arst_n(arst_n), .transfer_flush(transfer_flush),
	.wait_state(wait_state), .bus_hold(bus_hold), .busy(busy), .done(done),
	.op_out(op_out), .mem_operand(mem_operand), .modrm_out(modrm_out),
	.illegal(illegal));
